/* File: core/adcsp_port.v */
`timescale 1ns/1ps
`include "adcsp_defines.vh"
// Functional notes
// - chip select low frames each transaction
// - serial input sampled on sck rising
// - serial output updated on sck falling
// - modes 0,0 and 1,1; switch while deselected
// - sck and master clock independent, asynchronous
// - serial output high impedance while deselected
// - write or fast command: output released after command
// - address mismatch releases serial output
// - serial input ignored during register read
// - upper select bit picks interrupt pin role
// - lower select bit picks driven-high or released idle pin
// - bitstream mode outputs modulator bit stream
// - por or crc interrupt holds pin low
// - pin read back must be high when idle
// - clock pin is input or core-clock output
// - core clock is master clock over prescale
// - overrange saturates or wraps per layout
// - negative input may tie to analog ground
// - sample clock is core clock over four
// - data-ready pulse per new result
module adcsp_port #(
  parameter [1:0] DEV_ADDR = 2'h1,
  parameter OSR = 32,
  parameter DATA_W = 24
) (
  input wire clk_sys,
  input wire rst,
  input wire clk_en,
  input wire cs_n,
  input wire sck,
  input wire sdi,
  output reg sdo_o_ff,
  output reg sdo_oe_ff,
  input wire irq_pin_i,
  output reg irq_o_ff,
  output reg irq_oe_ff,
  input wire [1:0] pin_function_select,
  input wire clock_source_select,
  input wire [1:0] clock_divider_select,
  input wire master_clock_i,
  output reg analog_core_clock_ff,
  output reg mclk_oe_ff,
  input wire modulator_bit,
  input wire por_irq,
  input wire crc_irq,
  input wire irq_clear,
  input wire [DATA_W-1:0] read_data,
  input wire [1:0] output_word_layout,
  input wire [DATA_W:0] raw_result,
  input wire single_ended_sel,
  output reg vin_neg_to_gnd_ff,
  output reg [DATA_W-1:0] result_ff,
  output reg [7:0] cmd_ff,
  output reg cmd_valid_ff,
  output reg [DATA_W-1:0] wr_data_ff,
  output reg wr_valid_ff,
  output reg irq_idle_fault_ff
);
  // ****************************************
  // sck and cs are sampled as synchronous pins; edges detected here
  // ****************************************
  reg sck_d_ff;
  reg cs_d_ff;
  reg [7:0] bit_cnt_ff;
  reg [7:0] shift_in_ff;
  reg [DATA_W-1:0] wshift_ff;
  reg [DATA_W-1:0] rshift_ff;
  reg [4:0] wcnt_ff;
  reg is_read_ff;
  reg release_ff;
  // write words are only collected for an own-address incremental write
  reg wr_ok_ff;
  wire sck_rise = sck & ~sck_d_ff;
  wire sck_fall = ~sck & sck_d_ff;
  wire active = ~cs_n & ~cs_d_ff;
  wire [7:0] nxt_shift = {shift_in_ff[6:0], sdi};
  function is_rd;
    input [1:0] t;
    is_rd = (t == `ADCSP_TYPE_SREAD) | (t == `ADCSP_TYPE_IREAD);
  endfunction
  function is_wr;
    input [1:0] t;
    is_wr = (t == `ADCSP_TYPE_IWRITE);
  endfunction
  // ****************************************
  // command framing, shifting and serial output
  // ****************************************
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sck_d_ff <= 1'b0;
      cs_d_ff <= 1'b1;
      bit_cnt_ff <= 8'h00;
      shift_in_ff <= 8'h00;
      wshift_ff <= {DATA_W{1'b0}};
      rshift_ff <= {DATA_W{1'b0}};
      wcnt_ff <= 5'h00;
      is_read_ff <= 1'b0;
      release_ff <= 1'b0;
      wr_ok_ff <= 1'b0;
      sdo_o_ff <= 1'b0;
      sdo_oe_ff <= 1'b0;
      cmd_ff <= 8'h00;
      cmd_valid_ff <= 1'b0;
      wr_data_ff <= {DATA_W{1'b0}};
      wr_valid_ff <= 1'b0;
    end else if (clk_en) begin
      sck_d_ff <= sck;
      cs_d_ff <= cs_n;
      cmd_valid_ff <= 1'b0;
      wr_valid_ff <= 1'b0;
      if (cs_n) begin
        // any cs rise abandons a partial frame
        bit_cnt_ff <= 8'h00;
        wcnt_ff <= 5'h00;
        is_read_ff <= 1'b0;
        release_ff <= 1'b0;
        wr_ok_ff <= 1'b0;
        sdo_oe_ff <= 1'b0;
      end else if (active) begin
        if (sck_rise) begin
          if (bit_cnt_ff < `ADCSP_CMD_BITS) begin
            shift_in_ff <= nxt_shift;
            bit_cnt_ff <= bit_cnt_ff + 8'h01;
            if (bit_cnt_ff == 8'h01 && nxt_shift[1:0] != DEV_ADDR)
              release_ff <= 1'b1;
            if (bit_cnt_ff == 8'h07) begin
              cmd_ff <= nxt_shift;
              cmd_valid_ff <= ~release_ff;
              is_read_ff <= is_rd(nxt_shift[1:0]) & ~release_ff;
              wr_ok_ff <= is_wr(nxt_shift[1:0]) & ~release_ff;
              if (!is_rd(nxt_shift[1:0]))
                release_ff <= 1'b1;
              rshift_ff <= read_data;
            end
          end else if (wr_ok_ff) begin
            // read frames never shift sdi
            wshift_ff <= {wshift_ff[DATA_W-2:0], sdi};
            if (wcnt_ff == DATA_W - 1) begin
              wcnt_ff <= 5'h00;
              wr_data_ff <= {wshift_ff[DATA_W-2:0], sdi};
              wr_valid_ff <= 1'b1;
            end else begin
              wcnt_ff <= wcnt_ff + 5'h01;
            end
          end
        end
        if (sck_fall) begin
          if (release_ff) begin
            sdo_oe_ff <= 1'b0;
          end else if (bit_cnt_ff >= 8'h02) begin
            sdo_oe_ff <= 1'b1;
            if (is_read_ff) begin
              sdo_o_ff <= rshift_ff[DATA_W-1];
              rshift_ff <= {rshift_ff[DATA_W-2:0], 1'b0};
            end else begin
              sdo_o_ff <= 1'b0;
            end
          end
        end
        if (release_ff)
          sdo_oe_ff <= 1'b0;
      end
    end
  end

  // ****************************************
  // clock pin, prescaler and modulator/output-rate dividers
  // ****************************************
  // master clock sampled on clk_sys; it must be well below 100 MHz
  reg mck_d_ff;
  reg [2:0] pre_cnt_ff;
  reg [1:0] mod_cnt_ff;
  reg [15:0] osr_cnt_ff;
  reg [2:0] drdy_cnt_ff;
  reg [DATA_W-1:0] nxt_result;
  // both master clock edges count, so a prescale of one passes the clock through
  wire mck_edge = master_clock_i ^ mck_d_ff;
  function [2:0] pre_top;
    input [1:0] sel;
    case (sel)
      2'h0: pre_top = 3'h0;
      2'h1: pre_top = 3'h1;
      2'h2: pre_top = 3'h3;
      default: pre_top = 3'h7;
    endcase
  endfunction
  wire acc_tick = mck_edge & (pre_cnt_ff >= pre_top(clock_divider_select));
  wire core_rise = acc_tick & ~analog_core_clock_ff;
  wire mod_tick = core_rise & (mod_cnt_ff == `ADCSP_MOD_DIV - 1);
  wire overrange = raw_result[DATA_W] != raw_result[DATA_W-1];
  // ****************************************
  // result formatting
  // ****************************************
  always @* begin
    nxt_result = raw_result[DATA_W-1:0];
    // layout 0 clamps; other layouts keep the wrapped code for software to flag
    if (overrange && output_word_layout == 2'h0)
      nxt_result = raw_result[DATA_W] ? {1'b1, {(DATA_W-1){1'b0}}} : {1'b0, {(DATA_W-1){1'b1}}};
  end
  // ****************************************
  // prescaler and rate counters
  // ****************************************
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mck_d_ff <= 1'b0;
      pre_cnt_ff <= 3'h0;
      mod_cnt_ff <= 2'h0;
      osr_cnt_ff <= 16'h0000;
      drdy_cnt_ff <= 3'h0;
      analog_core_clock_ff <= 1'b0;
      mclk_oe_ff <= 1'b0;
      result_ff <= {DATA_W{1'b0}};
      vin_neg_to_gnd_ff <= 1'b0;
    end else if (clk_en) begin
      mck_d_ff <= master_clock_i;
      mclk_oe_ff <= clock_source_select;
      vin_neg_to_gnd_ff <= single_ended_sel;
      if (mck_edge) begin
        if (acc_tick) begin
          pre_cnt_ff <= 3'h0;
          analog_core_clock_ff <= ~analog_core_clock_ff;
        end else begin
          pre_cnt_ff <= pre_cnt_ff + 3'h1;
        end
      end
      if (core_rise)
        mod_cnt_ff <= mod_cnt_ff + 2'h1;
      if (drdy_cnt_ff != 3'h0)
        drdy_cnt_ff <= drdy_cnt_ff - 3'h1;
      if (mod_tick) begin
        if (osr_cnt_ff == OSR - 1) begin
          osr_cnt_ff <= 16'h0000;
          drdy_cnt_ff <= `ADCSP_DRDY_PULSE_CYC;
          result_ff <= nxt_result;
        end else begin
          osr_cnt_ff <= osr_cnt_ff + 16'h0001;
        end
      end
    end
  end

  // ****************************************
  // shared interrupt / bitstream pin
  // ****************************************
  reg lvl_irq_ff;
  reg [1:0] idle_chk_ff;
  reg nxt_lvl_irq;
  reg nxt_irq_o;
  reg nxt_irq_oe;
  wire drdy_low = (drdy_cnt_ff != 3'h0);
  wire bit_mode = pin_function_select[`ADCSP_PFS_MODE_BIT];
  // ****************************************
  // shared pin next value
  // ****************************************
  always @* begin
    // new por/crc event wins over a clear in the same cycle
    nxt_lvl_irq = (por_irq | crc_irq) | (lvl_irq_ff & ~irq_clear);
    nxt_irq_o = 1'b1;
    nxt_irq_oe = pin_function_select[`ADCSP_PFS_IDLE_BIT];
    if (lvl_irq_ff) begin
      nxt_irq_o = 1'b0;
      nxt_irq_oe = 1'b1;
    end else if (bit_mode) begin
      nxt_irq_o = modulator_bit;
      nxt_irq_oe = 1'b1;
    end else if (drdy_low) begin
      nxt_irq_o = 1'b0;
      nxt_irq_oe = 1'b1;
    end
  end
  // ****************************************
  // shared pin registers
  // ****************************************
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lvl_irq_ff <= 1'b0;
      irq_o_ff <= 1'b1;
      irq_oe_ff <= 1'b0;
      idle_chk_ff <= 2'h0;
      irq_idle_fault_ff <= 1'b0;
    end else if (clk_en) begin
      lvl_irq_ff <= nxt_lvl_irq;
      irq_o_ff <= nxt_irq_o;
      irq_oe_ff <= nxt_irq_oe;
      idle_chk_ff <= {idle_chk_ff[0], irq_o_ff & ~bit_mode};
      // only a pin meant high now and two cycles earlier may flag; a fresh low drive is no fault
      irq_idle_fault_ff <= idle_chk_ff[1] & irq_o_ff & ~bit_mode & ~irq_pin_i;
    end
  end
endmodule // adcsp_port

/* File: core/adcsp_defines.vh */
`ifndef ADCSP_DEFINES_VH
`define ADCSP_DEFINES_VH
// command byte fields
`define ADCSP_CMD_BITS 8
`define ADCSP_ADDR_HI 7
`define ADCSP_ADDR_LO 6
`define ADCSP_TYPE_HI 1
`define ADCSP_TYPE_LO 0
// command type codes
`define ADCSP_TYPE_FAST 2'h0
`define ADCSP_TYPE_SREAD 2'h1
`define ADCSP_TYPE_IWRITE 2'h2
`define ADCSP_TYPE_IREAD 2'h3
// pin function select bits and reset value
`define ADCSP_PFS_MODE_BIT 1
`define ADCSP_PFS_IDLE_BIT 0
`define ADCSP_PFS_RESET 2'h0
// clock divider, data-ready pulse length and sck limit
`define ADCSP_MOD_DIV 4
`define ADCSP_DRDY_PULSE_CYC 3'h4
`define ADCSP_SCK_MAX_MHZ 20
`endif

/* File: test/adcsp_port_assertions.sv */
`timescale 1ns/1ps
// ****
// port checker
// ****
module adcsp_chk #(
  parameter [1:0] DEV_ADDR = 2'h1
) (
  input wire clk_sys,
  input wire rst,
  input wire cs_n,
  input wire sdo_oe_ff,
  input wire [7:0] cmd_ff,
  input wire cmd_valid_ff,
  input wire irq_o_ff,
  input wire irq_oe_ff,
  input wire por_irq,
  input wire [1:0] pin_function_select,
  input wire clock_source_select,
  input wire mclk_oe_ff
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_cmd_wr;
    cmd_valid_ff && !cmd_ff[0];
  endsequence
  a_sdo_hiz_idle: assert property (cs_n && $past(cs_n) |-> !sdo_oe_ff)
    else $error("sdo driven while deselected");
  a_cs_rise_off: assert property ($rose(cs_n) |=> !sdo_oe_ff && !cmd_valid_ff)
    else $error("frame not closed on deselect");
  a_no_cmd_idle: assert property (cs_n [*3] |-> !cmd_valid_ff)
    else $error("command taken while deselected");
  a_addr_match: assert property (cmd_valid_ff |-> cmd_ff[7:6] == DEV_ADDR)
    else $error("command for other address taken");
  a_write_quiet: assert property (s_cmd_wr |=> !sdo_oe_ff [*8])
    else $error("sdo driven after write command");
  a_clk_pin_dir: assert property ($stable(clock_source_select) [*3] |->
    mclk_oe_ff == clock_source_select)
    else $error("clock pin direction wrong");
  a_irq_low_hold: assert property ($rose(por_irq) |-> ##[1:3] (irq_oe_ff && !irq_o_ff))
    else $error("pin not pulled low on interrupt");
  a_idle_hiz: assert property (pin_function_select == 2'h0 &&
    $past(pin_function_select) == 2'h0 |-> !(irq_oe_ff && irq_o_ff))
    else $error("pin driven high in released mode");
endmodule // adcsp_chk
bind adcsp_port adcsp_chk #(.DEV_ADDR(DEV_ADDR)) u_chk (.*);

/* File: test/adcsp_host.sv */
`timescale 1ns/1ps
// ****
// spi host model
// ****
module adcsp_host (
  output logic cs_n = 1'b1,
  output logic sck = 1'b0,
  output logic sdi = 1'b0,
  input wire sdo_line
);
  int i;
  task xfer(input logic [7:0] cmd, input logic [23:0] wd, input logic cpol,
    output logic [23:0] rd);
    sck = cpol; // mode only changes while deselected
    #40 cs_n = 1'b0; // frame opens
    for (i = 0; i < 32; i++) begin
      #30 sck = 1'b0;
      sdi = (i < 8) ? cmd[7-i] : wd[31-i]; // command byte, then data, msb first
      #30 sck = 1'b1; // 60 ns period stays below 20 MHz
      if (i > 7) rd = {rd[22:0], sdo_line};
    end
    #30 sck = cpol;
    #20 cs_n = 1'b1; // sck is back at idle; it moves outside frames only on a mode change
    sdi = ~sdi;
  endtask
endmodule // adcsp_host

/* File: test/adcsp_port_tb.sv */
`timescale 1ns/1ps
// ****
// bench
// ****
module adcsp_port_tb;
  logic clk_sys = 0, rst = 1, sdo_o, sdo_oe, irq_o, irq_oe, sel = 0, mclk = 0, tog = 0;
  logic modb = 0, por = 0, clr = 0, se = 0, acore, acp = 0, moe, vneg, cmdv, wrv, flt, cpol;
  logic [1:0] pfs = 2'h0, div = 2'h0;
  logic [23:0] rdata = 0, res, wdat, last_wr, wd, rd;
  logic [24:0] raw = 0;
  logic [7:0] cmd, cmdo;
  int error_cnt = 0, num_checks = 0, seed = 53940, n, ncmd = 0, nrise = 0, c0, e;
  int ndr = 0, d0, nr0;
  logic cen = 1, mrun = 1, ip = 1, ac0;
  wire cs_n, sck, sdi;
  wire sdo_line = sdo_oe ? sdo_o : tog; // released line shows a moving pattern
  wire irq_pin = irq_oe ? irq_o : 1'b1; // pull-up on the shared pin
  adcsp_host host (.cs_n(cs_n), .sck(sck), .sdi(sdi), .sdo_line(sdo_line));
  adcsp_port dut (.clk_sys(clk_sys), .rst(rst), .clk_en(cen), .cs_n(cs_n), .sck(sck),
    .sdi(sdi), .sdo_o_ff(sdo_o), .sdo_oe_ff(sdo_oe), .irq_pin_i(irq_pin), .irq_o_ff(irq_o),
    .irq_oe_ff(irq_oe), .pin_function_select(pfs), .clock_source_select(sel),
    .clock_divider_select(div), .master_clock_i(mclk), .analog_core_clock_ff(acore),
    .mclk_oe_ff(moe), .modulator_bit(modb), .por_irq(por), .crc_irq(1'b0), .irq_clear(clr),
    .read_data(rdata), .output_word_layout(2'h0), .raw_result(raw), .single_ended_sel(se),
    .vin_neg_to_gnd_ff(vneg), .result_ff(res), .cmd_ff(cmdo), .cmd_valid_ff(cmdv),
    .wr_data_ff(wdat), .wr_valid_ff(wrv), .irq_idle_fault_ff(flt));
  initial forever #2.5 clk_sys = ~clk_sys;
  always @(negedge clk_sys) begin
    tog <= ~tog;
    if (tog && mrun) mclk <= ~mclk;
    modb <= ^$random(seed);
  end
  function logic [23:0] sat(input logic [24:0] r);
    if (r[24] != r[23]) return r[24] ? 24'h800000 : 24'h7fffff;
    return r[23:0];
  endfunction
  always @(posedge clk_sys) begin
    acp <= acore;
    if (acore && !acp) nrise++;
    if (cmdv) ncmd++;
    if (wrv) last_wr <= wdat;
    ip <= irq_pin;
    if (ip && !irq_pin && pfs == 2'h0) ndr++;
  end
  task chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task end_of_test;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #200000 error_cnt++;
    end_of_test;
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys) rst = 0;
    repeat (4) @(negedge clk_sys);
    // every type in both modes, last four with a foreign address
    for (n = 0; n < 12; n++) begin
      cmd = {(n > 7) ? 2'h2 : 2'h1, 4'($random(seed)), 2'(n)};
      cpol = n[2];
      rdata = 24'($random(seed));
      wd = 24'($random(seed));
      c0 = ncmd;
      host.xfer(cmd, wd, cpol, rd);
      repeat (4) @(negedge clk_sys);
      chk(ncmd == c0 + ((n > 7) ? 0 : 1), "command count");
      if (n < 8) chk(cmdo === cmd, "command byte");
      if (n < 8 && cmd[0]) chk(rd === rdata, "read word");
      if (n < 8 && cmd[1:0] == 2'h2) chk(last_wr === wd, "write word");
    end
    sel = 1;
    raw = {2'h2, 23'($random(seed))};
    d0 = ndr;
    nr0 = nrise;
    for (n = 0; n < 4; n++) begin
      div = 2'(n);
      repeat (40) @(negedge clk_sys);
      c0 = nrise;
      repeat (512) @(negedge clk_sys);
      e = 128 >> n;
      chk(nrise - c0 >= e - 1 && nrise - c0 <= e + 1, "core clock rate");
      chk(moe === 1'b1, "clock pin output");
    end
    e = (nrise - nr0) / 128;
    chk(ndr - d0 >= e - 1 && ndr - d0 <= e + 1, "data-ready rate");
    chk(res === sat(raw), "overrange result");
    cen = 0;
    ac0 = acore;
    c0 = nrise;
    repeat (20) @(negedge clk_sys);
    chk(nrise == c0 && acore === ac0, "clock enable freeze");
    cen = 1;
    pfs = 2'h2;
    por = 1;
    @(negedge clk_sys) por = 0;
    repeat (20) @(negedge clk_sys);
    chk(irq_pin === 1'b0, "pin held low");
    clr = 1;
    @(negedge clk_sys) clr = 0;
    mrun = 0;
    pfs = 2'h1;
    se = 1;
    repeat (20) @(negedge clk_sys);
    chk(irq_pin === 1'b1 && flt === 1'b0, "idle pin level");
    chk(vneg === 1'b1, "negative input grounded");
    end_of_test;
  end
endmodule // adcsp_port_tb
